//--- common/pmp_pkg.sv
// constants and types shared by the port power-management preload loader
package pmp_pkg;
    // register port and preload store geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int WORD_W = 16;
    localparam int MEM_AW = 8;
    localparam int PSEL_LSB = 8;
    localparam int PSEL_W = 4;

    // configuration offsets inside one port's space
    localparam logic [7:0] OFS_PM_CAP = 8'h40;
    localparam logic [7:0] OFS_PM_CSR = 8'h44;
    // loader control and status, outside every port's space while NUM_PORTS stays below 16
    localparam logic [ADDR_W-1:0] ADDR_LDR = 12'hF00;
    localparam int LDR_START_BIT = 0;
    localparam int LDR_BUSY_BIT = 0;
    localparam int LDR_DONE_BIT = 1;
    localparam int LDR_ABSENT_BIT = 2;

    // preload store: first word of the first port, two words a port
    localparam logic [MEM_AW-1:0] PRE_BASE = 8'h54;
    localparam int PORT_FIRST = 2;
    localparam int NUM_PORTS_DEF = 4;

    // fields of the first preload word
    localparam int W_NSR_BIT = 0;
    localparam int W_AUX_LSB = 1;
    localparam int W_D1_BIT = 4;
    localparam int W_D2_BIT = 5;
    localparam int W_PME_LSB = 6;
    // field of the second preload word
    localparam int W_DATA_LSB = 8;

    // fields of the capability register (40h)
    localparam int CAP_ID_LSB = 0;
    localparam int CAP_NEXT_LSB = 8;
    localparam int CAP_VER_LSB = 16;
    localparam int CAP_AUX_LSB = 22;
    localparam int CAP_D1_BIT = 25;
    localparam int CAP_D2_BIT = 26;
    localparam int CAP_PME_LSB = 28;
    localparam logic [7:0] CAP_ID = 8'h01;
    localparam logic [2:0] CAP_VER = 3'h3;

    // fields of the control/status register (44h)
    localparam int CSR_PWR_LSB = 0;
    localparam int CSR_NSR_BIT = 3;
    localparam int CSR_DATA_LSB = 24;

    // values kept when no store is fitted
    localparam logic [7:0] RST_PM_BYTE = 8'h00;
    localparam logic [7:0] RST_DATA_BYTE = 8'h00;
    localparam logic [1:0] RST_PWR = 2'h0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PM = 2'b01,
        ST_DATA = 2'b11,
        ST_DONE = 2'b10
    } pmp_state_t;
endpackage

//--- src/pmp_port_regs.sv
// power-management capability and control/status registers of one port
module pmp_port_regs
    import pmp_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // preload side
    input wire logic ld_pm_in,
    input wire logic ld_data_in,
    input wire logic [WORD_W-1:0] word_in,
    // software side
    input wire logic pwr_we_in,
    input wire logic [1:0] pwr_in,
    input wire logic [7:0] next_ptr_in,
    // register images
    output logic [DATA_W-1:0] cap_out,
    output logic [DATA_W-1:0] csr_out
);
    typedef struct packed {
        logic [7:0] pm;
        logic [7:0] data;
        logic [1:0] pwr;
    } pmp_port_st_t;

    localparam pmp_port_st_t PORT_RST = '{RST_PM_BYTE, RST_DATA_BYTE, RST_PWR};

    pmp_port_st_t st_q;
    pmp_port_st_t st_d;

    always_comb
    begin
        st_d = st_q;
        if (ld_pm_in)
        begin
            st_d.pm = word_in[7:0];
        end
        if (ld_data_in)
        begin
            st_d.data = word_in[W_DATA_LSB+:8];
        end
        if (pwr_we_in)
        begin
            st_d.pwr = pwr_in;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            st_q <= PORT_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // preloaded fields are not writable from the register port
    always_comb
    begin
        cap_out = '0;
        cap_out[CAP_ID_LSB+:8] = CAP_ID;
        cap_out[CAP_NEXT_LSB+:8] = next_ptr_in;
        cap_out[CAP_VER_LSB+:3] = CAP_VER;
        cap_out[CAP_AUX_LSB+:3] = st_q.pm[W_AUX_LSB+:3];
        cap_out[CAP_D1_BIT] = st_q.pm[W_D1_BIT];
        cap_out[CAP_D2_BIT] = st_q.pm[W_D2_BIT];
        cap_out[CAP_PME_LSB+:2] = st_q.pm[W_PME_LSB+:2];
        csr_out = '0;
        csr_out[CSR_PWR_LSB+:2] = st_q.pwr;
        csr_out[CSR_NSR_BIT] = st_q.pm[W_NSR_BIT];
        csr_out[CSR_DATA_LSB+:8] = st_q.data;
    end
endmodule

//--- src/pmp_top.sv
// preload loader for per-port power-management settings, with register port
// Contract
// - first word bit 0 goes to no-soft-reset, bit 3 of offset 44h.
// - first word bits 3:1 go to aux current, bits 24:22 of 40h.
// - first word bit 4 sets read-only D1 support, bit 25 of 40h.
// - first word bit 5 sets read-only D2 support, bit 26 of 40h.
// - first word bits 7:6 go to PME support bits 29:28 of 40h.
// - second word bits 15:8 give read-only data byte, bits 31:24 of 44h.
// - first words of ports 3, 4, 5 come from 56h, 58h, 5Ah.
// - data words of ports 2, 3, 4 come from 55h, 57h, 59h.
//
// Chosen here: strobed register access and the placing of the registers.
module pmp_top
    import pmp_pkg::*;
#(
    parameter int NUM_PORTS = NUM_PORTS_DEF,
    parameter logic [7:0] NEXT_PTR = 8'h00
)
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [DATA_W-1:0] reg_rdata_out,
    // preload store
    input wire logic mem_present_in,
    output logic mem_req_out,
    output logic [MEM_AW-1:0] mem_addr_out,
    input wire logic mem_ack_in,
    input wire logic [WORD_W-1:0] mem_data_in,
    // status
    output logic cfg_ready_out
);
    localparam int PORT_W = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;
    localparam logic [PORT_W-1:0] LAST_PORT = PORT_W'(NUM_PORTS - 1);

    // the store window must end within the byte address space
    if (NUM_PORTS < 1 || NUM_PORTS > 16 ||
        int'(PRE_BASE) + 2 * NUM_PORTS > 256)
    begin : g_bad_ports
        $error("pmp_top: NUM_PORTS out of range");
    end

    typedef struct packed {
        pmp_state_t state;
        logic [PORT_W-1:0] port;
        logic pending;
        logic absent;
        logic req;
        logic [MEM_AW-1:0] addr;
        logic [DATA_W-1:0] rdata;
    } pmp_top_st_t;

    // a load is pending from reset so the ports fill without software help
    localparam pmp_top_st_t TOP_RST = '{ST_IDLE, '0, 1'b1, 1'b0, 1'b0,
                                        '0, '0};

    pmp_top_st_t st_q;
    pmp_top_st_t st_d;

    logic [NUM_PORTS-1:0] ld_pm;
    logic [NUM_PORTS-1:0] ld_data;
    logic [NUM_PORTS-1:0] pwr_we;
    logic [DATA_W-1:0] cap_img [NUM_PORTS];
    logic [DATA_W-1:0] csr_img [NUM_PORTS];
    logic ready;
    logic [PSEL_W-1:0] psel;
    logic [7:0] ofs;
    logic psel_ok;

    assign ready = (st_q.state == ST_DONE);
    assign psel = reg_addr_in[PSEL_LSB+:PSEL_W];
    assign ofs = reg_addr_in[7:0];
    assign psel_ok = (int'(psel) < NUM_PORTS);

    // one register bank per port
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi++)
        begin : g_port
            assign pwr_we[gi] = ready && reg_wr_in && psel_ok &&
                                (int'(psel) == gi) && (ofs == OFS_PM_CSR);
            pmp_port_regs u_regs (
                .clk_in(clk_in),
                .rstn_in(rstn_in),
                .ld_pm_in(ld_pm[gi]),
                .ld_data_in(ld_data[gi]),
                .word_in(mem_data_in),
                .pwr_we_in(pwr_we[gi]),
                .pwr_in(reg_wdata_in[CSR_PWR_LSB+:2]),
                .next_ptr_in(NEXT_PTR),
                .cap_out(cap_img[gi]),
                .csr_out(csr_img[gi])
            );
        end
    endgenerate

    always_comb
    begin
        st_d = st_q;
        ld_pm = '0;
        ld_data = '0;
        case (st_q.state)
            ST_IDLE:
            begin
                if (st_q.pending)
                begin
                    st_d.pending = 1'b0;
                    st_d.port = '0;
                    if (mem_present_in)
                    begin
                        st_d.absent = 1'b0;
                        st_d.req = 1'b1;
                        st_d.addr = PRE_BASE;
                        st_d.state = ST_PM;
                    end
                    else
                    begin
                        // no store: values already held stay in place
                        st_d.absent = 1'b1;
                        st_d.state = ST_DONE;
                    end
                end
            end
            ST_PM:
            begin
                if (mem_ack_in)
                begin
                    ld_pm[st_q.port] = 1'b1;
                    // data word sits right after the first word
                    st_d.addr = st_q.addr + 8'h01;
                    st_d.state = ST_DATA;
                end
            end
            ST_DATA:
            begin
                if (mem_ack_in)
                begin
                    ld_data[st_q.port] = 1'b1;
                    if (st_q.port == LAST_PORT)
                    begin
                        st_d.req = 1'b0;
                        st_d.state = ST_DONE;
                    end
                    else
                    begin
                        // next port's first word sits right after this port's data word
                        st_d.port = st_q.port + 1'b1;
                        st_d.addr = st_q.addr + 8'h01;
                        st_d.state = ST_PM;
                    end
                end
            end
            ST_DONE:
            begin
                if (reg_wr_in && reg_addr_in == ADDR_LDR &&
                    reg_wdata_in[LDR_START_BIT])
                begin
                    st_d.pending = 1'b1;
                    st_d.state = ST_IDLE;
                end
            end
            default:
            begin
                st_d = TOP_RST;
            end
        endcase

        // read data stand for the one cycle after the strobe
        st_d.rdata = '0;
        if (reg_rd_in)
        begin
            if (reg_addr_in == ADDR_LDR)
            begin
                st_d.rdata[LDR_BUSY_BIT] = !ready;
                st_d.rdata[LDR_DONE_BIT] = ready;
                st_d.rdata[LDR_ABSENT_BIT] = st_q.absent;
            end
            else if (ready && psel_ok && ofs == OFS_PM_CAP)
            begin
                st_d.rdata = cap_img[psel[PORT_W-1:0]];
            end
            else if (ready && psel_ok && ofs == OFS_PM_CSR)
            begin
                st_d.rdata = csr_img[psel[PORT_W-1:0]];
            end
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            st_q <= TOP_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign reg_rdata_out = st_q.rdata;
    assign mem_req_out = st_q.req;
    assign mem_addr_out = st_q.addr;
    assign cfg_ready_out = ready;
endmodule

//--- tb/pmp_store_model.sv
// preload store model answering after a settable number of waits
module pmp_store_model
    import pmp_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // loader side
    input wire logic req_in,
    input wire logic [MEM_AW-1:0] addr_in,
    input wire logic [3:0] wait_in,
    output logic ack_out,
    output logic [WORD_W-1:0] data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [WORD_W-1:0] mem_q [256];
    logic [3:0] cnt_q;
    // data toggles outside an answer so a stale word never looks valid
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            ack_out <= 1'b0;
            cnt_q <= 4'h0;
            data_out <= 16'hFFFF;
        end
        else if (req_in && !ack_out && cnt_q >= wait_in)
        begin
            ack_out <= 1'b1;
            cnt_q <= 4'h0;
            data_out <= mem_q[addr_in];
        end
        else
        begin
            ack_out <= 1'b0;
            data_out <= ~data_out;
            cnt_q <= (req_in && !ack_out) ? cnt_q + 4'h1 : 4'h0;
        end
    end
endmodule

//--- tb/pmp_top_sva.sv
// port assertions for the preload loader
module pmp_top_sva
    import pmp_pkg::*;
#(
    parameter int NUM_PORTS = NUM_PORTS_DEF
)
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic reg_rd_in,
    input wire logic [DATA_W-1:0] reg_rdata_out,
    input wire logic mem_req_out,
    input wire logic [MEM_AW-1:0] mem_addr_out,
    input wire logic mem_ack_in,
    input wire logic [WORD_W-1:0] mem_data_in,
    input wire logic cfg_ready_out
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] LAST = PRE_BASE + 8'(2 * NUM_PORTS - 1);
    logic [WORD_W-1:0] w1_q [NUM_PORTS];
    logic [WORD_W-1:0] w2_q [NUM_PORTS];
    logic [7:0] off;
    logic hit;
    logic cap_q;
    logic csr_q;
    int p_q;
    assign off = mem_addr_out - PRE_BASE;
    assign hit = reg_rd_in && cfg_ready_out
        && int'(reg_addr_in[11:8]) < NUM_PORTS;
    // shadow of every word taken, to judge later register reads
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            w1_q <= '{default: '0};
            w2_q <= '{default: '0};
            cap_q <= 1'b0;
            csr_q <= 1'b0;
            p_q <= 0;
        end
        else
        begin
            if (mem_req_out && mem_ack_in && off[0])
                w2_q[off[7:1]] <= mem_data_in;
            if (mem_req_out && mem_ack_in && !off[0])
                w1_q[off[7:1]] <= mem_data_in;
            cap_q <= hit && reg_addr_in[7:0] == OFS_PM_CAP;
            csr_q <= hit && reg_addr_in[7:0] == OFS_PM_CSR;
            p_q <= int'(reg_addr_in[11:8]);
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    property p_nsr; csr_q |-> reg_rdata_out[3] == w1_q[p_q][0]; endproperty
    a_nsr: assert property (p_nsr) else $error("nsr bit");
    property p_aux; cap_q |-> reg_rdata_out[24:22] == w1_q[p_q][3:1];
    endproperty
    a_aux: assert property (p_aux) else $error("aux field");
    property p_d1; cap_q |-> reg_rdata_out[25] == w1_q[p_q][4]; endproperty
    a_d1: assert property (p_d1) else $error("d1 flag");
    property p_d2; cap_q |-> reg_rdata_out[26] == w1_q[p_q][5]; endproperty
    a_d2: assert property (p_d2) else $error("d2 flag");
    property p_pme; cap_q |-> reg_rdata_out[29:28] == w1_q[p_q][7:6];
    endproperty
    a_pme: assert property (p_pme) else $error("pme bits");
    property p_dat; csr_q |-> reg_rdata_out[31:24] == w2_q[p_q][15:8];
    endproperty
    a_dat: assert property (p_dat) else $error("data byte");
    property p_base; $rose(mem_req_out) |-> mem_addr_out == PRE_BASE;
    endproperty
    a_base: assert property (p_base) else $error("first addr");
    property p_step; mem_req_out && mem_ack_in && mem_addr_out != LAST
        |=> mem_req_out && mem_addr_out == $past(mem_addr_out) + 8'h01;
    endproperty
    a_step: assert property (p_step) else $error("addr step");
    property p_end; mem_req_out && mem_ack_in && mem_addr_out == LAST
        |=> !mem_req_out ##[0:1] cfg_ready_out; endproperty
    a_end: assert property (p_end) else $error("load end");
    c_load: cover property (mem_ack_in && mem_addr_out == LAST);
    c_cap: cover property (cap_q);
    c_busy: cover property (reg_rd_in && !cfg_ready_out);
endmodule
bind pmp_top pmp_top_sva #(.NUM_PORTS(NUM_PORTS)) u_sva (.clk_in(clk_in),
    .rstn_in(rstn_in), .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .mem_req_out(mem_req_out),
    .mem_addr_out(mem_addr_out), .mem_ack_in(mem_ack_in),
    .mem_data_in(mem_data_in), .cfg_ready_out(cfg_ready_out));

//--- tb/pmp_top_tb.sv
// self-checking bench for the preload loader
module pmp_top_tb;
    import pmp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic present = 1'b1;
    logic req, ack, ready;
    logic [MEM_AW-1:0] maddr;
    logic [WORD_W-1:0] mdata;
    logic [3:0] wt = 4'h0;
    logic [WORD_W-1:0] w [8];
    int errors = 0;
    int samples_checked = 0;
    int seed = 32'h2122;
    always #5 clk_in = ~clk_in;
    pmp_top dut (.clk_in(clk_in), .rstn_in(rstn_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .mem_present_in(present), .mem_req_out(req),
        .mem_addr_out(maddr), .mem_ack_in(ack), .mem_data_in(mdata),
        .cfg_ready_out(ready));
    pmp_store_model sm (.clk_in(clk_in), .rstn_in(rstn_in), .req_in(req),
        .addr_in(maddr), .wait_in(wt), .ack_out(ack), .data_out(mdata));
    function automatic logic [31:0] cap(input logic [15:0] v);
        return {2'h0, v[7:6], 1'h0, v[5:4], v[3:1], 6'h03, 16'h0001};
    endfunction
    function automatic logic [31:0] csr(input logic [15:0] a, b,
        input logic [1:0] p);
        return {b[15:8], 20'h0, a[0], 1'b0, p};
    endfunction
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1;
        samples_checked++;
        if (rdata !== e)
        begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, rdata, e);
        end
    endtask
    task automatic fill(input logic on, input logic [3:0] t);
        @(posedge clk_in);
        for (int i = 0; i < 8; i++)
        begin
            w[i] = (i == 0) ? 16'hFFFF : 16'($random(seed));
            // an absent store still holds words, so a load would show
            sm.mem_q[PRE_BASE + i] = w[i];
            w[i] = on ? w[i] : 16'h0000;
        end
        present <= on;
        wt <= t;
    endtask
    task automatic wait_ready();
        int n = 0;
        while (ready !== 1'b1 && n < 500)
        begin
            @(posedge clk_in);
            n++;
        end
        if (ready !== 1'b1)
        begin
            errors++;
            complete_run();
        end
    endtask
    task automatic chk_ports(input logic [1:0] p);
        for (int i = 0; i < NUM_PORTS_DEF; i++)
        begin
            rd_chk({i[3:0], OFS_PM_CAP}, cap(w[2*i]));
            rd_chk({i[3:0], OFS_PM_CSR},
                csr(w[2*i], w[2*i+1], p));
        end
    endtask
    initial
    begin
        fill(1'b1, 4'h0);
        repeat (9) @(posedge clk_in);
        rstn_in <= 1'b1;
        wait_ready();
        chk_ports(2'h0);
        $display("test preload done");
        for (int i = 0; i < NUM_PORTS_DEF; i++)
        begin
            wr_reg({i[3:0], OFS_PM_CSR}, 32'hFFFFFFFF);
            rd_chk({i[3:0], OFS_PM_CSR},
                csr(w[2*i], w[2*i+1], 2'h3));
            wr_reg({i[3:0], OFS_PM_CSR}, 32'h0);
            wr_reg({i[3:0], OFS_PM_CAP}, ~cap(w[2*i]));
            rd_chk({i[3:0], OFS_PM_CAP}, cap(w[2*i]));
        end
        rd_chk(12'h048, 32'h0);
        rd_chk(12'h440, 32'h0);
        $display("test read-only done");
        fill(1'b1, 4'h3);
        wr_reg(ADDR_LDR, 32'h1);
        rd_chk(12'h040, 32'h0);
        rd_chk(ADDR_LDR, 32'h1);
        wait_ready();
        chk_ports(2'h0);
        rd_chk(ADDR_LDR, 32'h2);
        $display("test reload done");
        fill(1'b0, 4'h0);
        rstn_in <= 1'b0;
        repeat (10) @(posedge clk_in);
        rstn_in <= 1'b1;
        wait_ready();
        chk_ports(2'h0);
        rd_chk(ADDR_LDR, 32'h6);
        $display("test no store done");
        complete_run();
    end
endmodule
